/* tdi_defs.vh */
// Purpose: constants of the tape drive interface controller
// Assumes: 25 MHz controller clock, word-indexed wishbone registers
// Notes:   byte address of a register is four times its index
`ifndef TDI_DEFS_VH
`define TDI_DEFS_VH

// ==========================================================
// register indices
`define TDI_IDX_CMD    6'h00
`define TDI_IDX_STAT   6'h01
`define TDI_IDX_WDATA  6'h02
`define TDI_IDX_RDATA  6'h03
`define TDI_IDX_LRC    6'h04

// ==========================================================
// command register fields
`define TDI_CMD_SEL_LSB 0
`define TDI_CMD_SEL_MSB 2
`define TDI_CMD_SEL_EN  3
`define TDI_CMD_WRITE   4
`define TDI_CMD_FWD     5
`define TDI_CMD_REV     6
`define TDI_CMD_EDIT    7
`define TDI_CMD_HIDEN   8
`define TDI_CMD_REWIND  9
`define TDI_CMD_ENDREC  10
`define TDI_CMD_RESET   11'h000

// ==========================================================
// status register fields
`define TDI_ST_ONLINE   0
`define TDI_ST_READY    1
`define TDI_ST_LOADPT   2
`define TDI_ST_TAPEEND  3
`define TDI_ST_REWIND   4
`define TDI_ST_PROTECT  5
`define TDI_ST_SEVEN    6
`define TDI_ST_SPEED    7
`define TDI_ST_NRZ      8
`define TDI_ST_BUSY     9
`define TDI_ST_REFUSED  10
`define TDI_ST_RDVALID  11
`define TDI_ST_OVERRUN  12
`define TDI_ST_RDPERR   13

// ==========================================================
// read data register fields
`define TDI_RD_PAR      8
`define TDI_RD_PERR     9
`define TDI_RD_VALID    10

// ==========================================================
// timing
`define TDI_CLK_NS      40
`define TDI_SETUP_NS    400
`define TDI_PULSE_NS    1000
`define TDI_SETUP_CYC   ((`TDI_SETUP_NS + `TDI_CLK_NS - 1) / `TDI_CLK_NS)
`define TDI_PULSE_CYC   ((`TDI_PULSE_NS + `TDI_CLK_NS - 1) / `TDI_CLK_NS)

`endif

/* tdi_sync.v */
// Purpose: two flip-flop synchroniser for the drive lines
// Assumes: inputs asynchronous to i_clock
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps

module tdi_sync
#(
  parameter WIDTH = 19
)
(
  input  wire             i_clock, // controller clock
  input  wire             i_reset, // sync reset, active high
  input  wire [WIDTH-1:0] i_async, // raw pin levels
  output wire [WIDTH-1:0] o_sync   // synchronised levels
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge i_clock)
      begin
        if (i_reset)
        begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end
        else
        begin
          meta_reg <= i_async[g];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[g] = sync_reg;
    end
  endgenerate

endmodule

/* tdi_parity.v */
// Purpose: odd character parity and longitudinal check accumulator
// Assumes: one character folded in per i_add pulse
// Notes:   accumulator covers all nine tracks
`timescale 1ns/1ps

module tdi_parity
(
  input  wire       i_clock, // controller clock
  input  wire       i_reset, // sync reset, active high
  input  wire [7:0] i_char,  // character to send
  input  wire       i_add,   // fold character into check
  input  wire       i_clear, // start a new record
  output wire       o_odd,   // parity bit for odd count
  output reg  [8:0] o_lrc    // check character with parity track
);

  assign o_odd = ~^i_char;

  always @(posedge i_clock)
  begin
    if (i_reset || i_clear)
      o_lrc <= 9'h000;
    else if (i_add)
      o_lrc <= o_lrc ^ {o_odd, i_char};
  end

endmodule

/* tdi_ctrl.v */
// Purpose: controller side of the parallel tape drive interface
// Assumes: classic wishbone slave, drive lines asynchronous
// Notes:   every drive line is active low at the pins
`timescale 1ns/1ps
`include "tdi_defs.vh"

// Behaviour
// RULE1: all drive lines are asserted when low, both directions.
// RULE2: eight select outputs, output n selects drive n.
// RULE3: select output chosen from the command register select field.
// RULE4: never more than one select output asserted.
// RULE5: write enable asserted only for write operations.
// RULE6: forward output moves the selected drive forward.
// RULE7: reverse output moves the selected drive backward.
// RULE8: rewind output is pulsed for a high-speed rewind.
// RULE9: overwrite output places the drive in edit mode.
// RULE10: density output asserted for high, released for low density.
// RULE11: drive reports on-line, ready, load point, tape end, rewinding.
// RULE12: drive reports file protect, writes are then impossible.
// RULE13: refuse write start while protected or not ready.
// RULE14: drive reports seven-track on its own line, high for nine.
// RULE15: speed line shows tape speed, or density for seven-track.
// RULE16: recording-method line low for NRZ, high for PE.
// RULE17: write character sent on eight data lines plus parity.
// RULE18: write parity makes the character's one count odd.
// RULE19: write strobe pulsed per character while data is stable.
// RULE20: amplifier reset pulse closes each record.
// RULE21: check character gives every track even parity.
// RULE22: threshold-two output left unused, held inactive.
// RULE23: read data and parity captured on the read strobe.
// RULE24: no read strobe expected for an all-zero check character.
module tdi_ctrl
(
  input  wire        i_clock,                 // 25 MHz clock
  input  wire        i_reset,                 // sync reset, active high
  input  wire        i_wb_cyc,                // wishbone cycle
  input  wire        i_wb_stb,                // wishbone strobe
  input  wire        i_wb_we,                 // wishbone write
  input  wire [7:0]  i_wb_adr,                // byte address
  input  wire [3:0]  i_wb_sel,                // byte enables
  input  wire [31:0] i_wb_dat,                // write data
  output reg  [31:0] o_wb_dat,                // read data
  output reg         o_wb_ack,                // acknowledge
  output reg  [7:0]  o_drive_select_n,        // drive selects
  output reg         o_write_enable_out_n,    // write enable
  output reg         o_sync_forward_cmd_n,    // forward motion
  output reg         o_sync_reverse_cmd_n,    // reverse motion
  output reg         o_rewind_cmd_n,          // rewind pulse
  output reg         o_edit_mode_cmd_n,       // edit mode
  output reg         o_high_density_select_n, // high density
  output reg  [7:0]  o_write_data_n,          // write data bus
  output reg         o_write_parity_line_n,   // write parity
  output reg         o_write_char_strobe_n,   // write strobe
  output reg         o_write_amp_reset_n,     // amplifier reset
  output reg         o_read_threshold_two_n,  // unused threshold
  input  wire        i_drive_on_line_n,       // on line
  input  wire        i_drive_ready_n,         // ready
  input  wire        i_at_load_point_n,       // load point
  input  wire        i_at_tape_end_marker_n,  // tape end
  input  wire        i_drive_rewinding_n,     // rewinding
  input  wire        i_write_protected_n,     // file protect
  input  wire        i_seven_track_n,         // seven-track unit
  input  wire        i_speed_indicator_n,     // speed or density
  input  wire        i_nrz_unit_n,            // recording method
  input  wire [7:0]  i_read_data_n,           // read data bus
  input  wire        i_read_parity_line_n,    // read parity
  input  wire        i_read_char_strobe_n     // read strobe
);

  // ==========================================================
  // constants
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_SETUP = 4'h2;
  localparam [3:0] ST_PULSE = 4'h4;
  localparam [3:0] ST_HOLD  = 4'h8;
  localparam [2:0] OP_CHAR  = 3'h1;
  localparam [2:0] OP_RWD   = 3'h2;
  localparam [2:0] OP_END   = 3'h4;
  localparam integer SETUP_INT = `TDI_SETUP_CYC;
  localparam integer PULSE_INT = `TDI_PULSE_CYC;
  localparam [5:0] SETUP_CYC = SETUP_INT[5:0];
  localparam [5:0] PULSE_CYC = PULSE_INT[5:0];

  // ==========================================================
  // input synchronisers
  wire [18:0] pins_sync;
  wire [18:0] pins_raw;
  assign pins_raw = {i_read_char_strobe_n, i_read_parity_line_n, i_read_data_n,
                     i_nrz_unit_n, i_speed_indicator_n, i_seven_track_n,
                     i_write_protected_n, i_drive_rewinding_n, i_at_tape_end_marker_n,
                     i_at_load_point_n, i_drive_ready_n, i_drive_on_line_n};

  tdi_sync #(.WIDTH(19)) u_sync
  (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_async (pins_raw),
    .o_sync  (pins_sync)
  );

  // low on the wire means asserted
  wire [8:0] drv_status = ~pins_sync[8:0]; // RULE1 RULE11 RULE14 RULE15 RULE16
  wire [8:0] rd_char    = ~pins_sync[17:9]; // RULE1
  wire       rd_strobe  = ~pins_sync[18];
  wire       protect    = drv_status[`TDI_ST_PROTECT];
  wire       ready      = drv_status[`TDI_ST_READY];

  // ==========================================================
  // state
  reg [10:0] cmd_reg;
  reg [3:0]  state_reg;
  reg [2:0]  op_reg;
  reg [5:0]  cnt_reg;
  reg [7:0]  wchar_reg;
  reg        refused_reg;
  reg        rd_strobe_reg;
  reg [8:0]  rd_data_reg;
  reg        rd_valid_reg;
  reg        rd_perr_reg;
  reg        overrun_reg;
  reg [8:0]  rec_lrc_reg;

  wire       busy = (state_reg != ST_IDLE);
  wire       req  = i_wb_cyc & i_wb_stb;
  wire       wr   = req & i_wb_we & o_wb_ack;
  wire       rd   = req & ~i_wb_we & o_wb_ack;
  wire [5:0] idx  = i_wb_adr[7:2];

  wire       w_cmd   = wr & (idx == `TDI_IDX_CMD) & i_wb_sel[0];
  wire       w_cmdh  = wr & (idx == `TDI_IDX_CMD) & i_wb_sel[1];
  wire       w_stat  = wr & (idx == `TDI_IDX_STAT) & i_wb_sel[1];
  wire       w_data  = wr & (idx == `TDI_IDX_WDATA) & i_wb_sel[0];
  wire       r_data  = rd & (idx == `TDI_IDX_RDATA);

  // write start refused on protect or not ready
  wire       want_write = w_cmd & i_wb_dat[`TDI_CMD_WRITE];
  wire       bad_drive  = protect | ~ready;
  wire       write_ok   = cmd_reg[`TDI_CMD_WRITE] & ~bad_drive;
  wire       char_go    = w_data & ~busy & write_ok;
  wire       char_bad   = w_data & (busy | ~write_ok);
  wire       rwd_go     = w_cmdh & i_wb_dat[`TDI_CMD_REWIND] & ~busy;
  wire       end_go     = w_cmdh & i_wb_dat[`TDI_CMD_ENDREC] & ~busy & write_ok;

  wire       par_odd;
  wire [8:0] lrc;

  tdi_parity u_par
  (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_char  (wchar_reg),
    .i_add   (state_reg == ST_PULSE && op_reg == OP_CHAR && cnt_reg == 6'h00),
    .i_clear (state_reg == ST_HOLD && op_reg == OP_END && cnt_reg == 6'h00),
    .o_odd   (par_odd),
    .o_lrc   (lrc)
  );

  // ==========================================================
  // command register
  always @(posedge i_clock)
  begin
    if (i_reset)
      cmd_reg <= `TDI_CMD_RESET;
    else
    begin
      if (w_cmd)
      begin
        cmd_reg[7:0] <= i_wb_dat[7:0];
        cmd_reg[`TDI_CMD_WRITE] <= want_write & ~bad_drive; // RULE13
      end
      else if (bad_drive)
        cmd_reg[`TDI_CMD_WRITE] <= 1'b0; // RULE12
      if (w_cmdh)
        cmd_reg[`TDI_CMD_HIDEN] <= i_wb_dat[`TDI_CMD_HIDEN];
    end
  end

  // ==========================================================
  // strobe sequencer: setup, pulse, hold
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_CHAR;
      cnt_reg   <= 6'h00;
      wchar_reg <= 8'h00;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (char_go)
          begin
            wchar_reg <= i_wb_dat[7:0];
            op_reg    <= OP_CHAR;
            cnt_reg   <= SETUP_CYC;
            state_reg <= ST_SETUP;
          end
          else if (end_go)
          begin
            op_reg    <= OP_END;
            cnt_reg   <= SETUP_CYC;
            state_reg <= ST_SETUP;
          end
          else if (rwd_go)
          begin
            op_reg    <= OP_RWD;
            cnt_reg   <= SETUP_CYC;
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          if (cnt_reg == 6'h01)
          begin
            cnt_reg   <= 6'h00;
            state_reg <= ST_PULSE;
          end
          else
            cnt_reg <= cnt_reg - 6'h01;
        end
        ST_PULSE:
        begin
          if (cnt_reg == PULSE_CYC - 6'h01)
          begin
            cnt_reg   <= SETUP_CYC;
            state_reg <= ST_HOLD;
          end
          else
            cnt_reg <= cnt_reg + 6'h01;
        end
        ST_HOLD:
        begin
          if (cnt_reg == 6'h00)
            state_reg <= ST_IDLE;
          else
            cnt_reg <= cnt_reg - 6'h01;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // drive pins, all active low
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_drive_select_n        <= 8'hFF;
      o_write_enable_out_n    <= 1'b1;
      o_sync_forward_cmd_n    <= 1'b1;
      o_sync_reverse_cmd_n    <= 1'b1;
      o_rewind_cmd_n          <= 1'b1;
      o_edit_mode_cmd_n       <= 1'b1;
      o_high_density_select_n <= 1'b1;
      o_write_data_n          <= 8'hFF;
      o_write_parity_line_n   <= 1'b1;
      o_write_char_strobe_n   <= 1'b1;
      o_write_amp_reset_n     <= 1'b1;
      o_read_threshold_two_n  <= 1'b1;
    end
    else
    begin
      o_drive_select_n <= ~(cmd_reg[`TDI_CMD_SEL_EN] ?
                            (8'h01 << cmd_reg[`TDI_CMD_SEL_MSB:`TDI_CMD_SEL_LSB]) :
                            8'h00); // RULE2 RULE3 RULE4
      o_write_enable_out_n    <= ~write_ok; // RULE5
      o_sync_forward_cmd_n    <= ~(cmd_reg[`TDI_CMD_FWD] & ~cmd_reg[`TDI_CMD_REV]); // RULE6
      o_sync_reverse_cmd_n    <= ~(cmd_reg[`TDI_CMD_REV] & ~cmd_reg[`TDI_CMD_FWD]); // RULE7
      o_edit_mode_cmd_n       <= ~cmd_reg[`TDI_CMD_EDIT]; // RULE9
      o_high_density_select_n <= ~cmd_reg[`TDI_CMD_HIDEN]; // RULE10
      o_read_threshold_two_n  <= 1'b1; // RULE22
      o_rewind_cmd_n <= ~(state_reg == ST_PULSE && op_reg == OP_RWD); // RULE8
      o_write_char_strobe_n <= ~(state_reg == ST_PULSE && op_reg == OP_CHAR); // RULE19
      o_write_amp_reset_n <= ~(state_reg == ST_PULSE && op_reg == OP_END); // RULE20
      if (busy && op_reg == OP_CHAR)
      begin
        o_write_data_n        <= ~wchar_reg; // RULE17
        o_write_parity_line_n <= ~par_odd; // RULE18
      end
      else
      begin
        o_write_data_n        <= 8'hFF;
        o_write_parity_line_n <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read capture and status flags
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      rd_strobe_reg <= 1'b0;
      rd_data_reg   <= 9'h000;
      rd_valid_reg  <= 1'b0;
      rd_perr_reg   <= 1'b0;
      overrun_reg   <= 1'b0;
      refused_reg   <= 1'b0;
      rec_lrc_reg   <= 9'h000;
    end
    else
    begin
      rd_strobe_reg <= rd_strobe;
      // capture only on strobes; a missing check strobe is never waited on
      if (rd_strobe && !rd_strobe_reg)
      begin
        rd_data_reg  <= rd_char; // RULE23 RULE24
        rd_perr_reg  <= ~^rd_char;
        rd_valid_reg <= 1'b1;
      end
      else if (r_data)
        rd_valid_reg <= 1'b0;
      if (rd_strobe && !rd_strobe_reg && rd_valid_reg && !r_data)
        overrun_reg <= 1'b1;
      else if (w_stat && i_wb_dat[`TDI_ST_OVERRUN])
        overrun_reg <= 1'b0;
      if (char_bad || (want_write && bad_drive) || (w_cmdh && i_wb_dat[`TDI_CMD_ENDREC] && !end_go))
        refused_reg <= 1'b1; // RULE13
      else if (w_stat && i_wb_dat[`TDI_ST_REFUSED])
        refused_reg <= 1'b0;
      if (state_reg == ST_PULSE && op_reg == OP_END && cnt_reg == 6'h00)
        rec_lrc_reg <= lrc; // RULE21
    end
  end

  // ==========================================================
  // wishbone slave, answer one cycle after the request
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end
    else
    begin
      o_wb_ack <= req & ~o_wb_ack;
      if (req && !o_wb_ack)
      begin
        case (idx)
          `TDI_IDX_CMD:
            o_wb_dat <= {21'h000000, cmd_reg[10:9] & 2'h0, cmd_reg[8:0]};
          `TDI_IDX_STAT:
            o_wb_dat <= {18'h00000, rd_perr_reg, overrun_reg, rd_valid_reg,
                         refused_reg, busy, drv_status};
          `TDI_IDX_RDATA:
            o_wb_dat <= {21'h000000, rd_valid_reg, rd_perr_reg, rd_data_reg};
          `TDI_IDX_LRC:
            o_wb_dat <= {23'h000000, rec_lrc_reg};
          default:
            o_wb_dat <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

/* tdi_ctrl_sva.sv */
// Purpose: concurrent checks on the tape drive interface controller ports
// Assumes: single clock domain, sync active-high reset
// Notes:   drive lines are active low
`timescale 1ns/1ps

module tdi_ctrl_sva
(
  input wire        i_clock,                // clock
  input wire        i_reset,                // reset
  input wire        i_wb_cyc,               // bus cycle
  input wire        i_wb_stb,               // bus strobe
  input wire        i_wb_we,                // bus write
  input wire [7:0]  i_wb_adr,               // bus address
  input wire [3:0]  i_wb_sel,               // byte enables
  input wire [31:0] i_wb_dat,               // bus write data
  input wire        o_wb_ack,               // bus ack
  input wire [7:0]  o_drive_select_n,       // selects
  input wire        o_write_enable_out_n,   // write enable
  input wire        o_sync_forward_cmd_n,   // forward
  input wire        o_sync_reverse_cmd_n,   // reverse
  input wire        o_rewind_cmd_n,         // rewind
  input wire [7:0]  o_write_data_n,         // write data
  input wire        o_write_parity_line_n,  // write parity
  input wire        o_write_char_strobe_n,  // write strobe
  input wire        o_write_amp_reset_n,    // amp reset
  input wire        o_read_threshold_two_n, // threshold two
  input wire        i_write_protected_n     // file protect
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  // ==========================================================
  // helpers
  wire       cmd_wr   = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[0] && i_wb_adr[7:2] == 6'h00;
  wire [7:0] want_sel = i_wb_dat[3] ? ~(8'h01 << i_wb_dat[2:0]) : 8'hFF;
  reg  [7:0] low_cnt;

  // strobe low time in cycles
  always @(posedge i_clock)
    if (i_reset || o_write_char_strobe_n)
      low_cnt <= 8'h00;
    else
      low_cnt <= low_cnt + 8'h01;

  // ==========================================================
  // properties
  a_one_select: assert property ($countones(~o_drive_select_n) <= 1)
    else $error("more than one drive select low");
  a_select_follows: assert property (cmd_wr |-> ##2 o_drive_select_n == $past(want_sel, 2))
    else $error("drive select does not follow command");
  a_no_threshold: assert property (o_read_threshold_two_n)
    else $error("threshold two driven");
  a_motion_exclusive: assert property (!(!o_sync_forward_cmd_n && !o_sync_reverse_cmd_n))
    else $error("forward and reverse together");
  a_rewind_pulse: assert property ($fell(o_rewind_cmd_n) |-> ##25 $rose(o_rewind_cmd_n))
    else $error("rewind pulse width wrong");
  a_amp_pulse: assert property ($fell(o_write_amp_reset_n) |=> (!o_write_amp_reset_n)[*8] ##17
    $rose(o_write_amp_reset_n))
    else $error("amp reset pulse width wrong");
  a_strobe_width: assert property ($rose(o_write_char_strobe_n) |-> low_cnt == 8'h19)
    else $error("write strobe width wrong");
  a_data_held: assert property (!o_write_char_strobe_n |-> $stable(o_write_data_n) && $stable(o_write_parity_line_n))
    else $error("write data moved under strobe");
  a_odd_parity: assert property (!o_write_char_strobe_n |-> ^{~o_write_data_n, ~o_write_parity_line_n})
    else $error("write parity not odd");
  a_strobe_needs_we: assert property (!o_write_char_strobe_n |-> !o_write_enable_out_n)
    else $error("strobe without write enable");
  a_protect_blocks: assert property ((!i_write_protected_n)[*8] |-> o_write_enable_out_n)
    else $error("write enable while protected");
endmodule

/* tdi_drive_model.sv */
// Purpose: behavioural model of one daisy-chained tape drive
// Assumes: status and input capture only while its select line is low; send_char drives read lines regardless
// Notes:   unselected status lines float high on terminators
`timescale 1ns/1ps

module tdi_drive_model
#(
  parameter DRIVE_NO = 3
)
(
  input  wire [7:0] i_select_n,    // drive selects
  input  wire [8:0] i_status,      // status, active high
  input  wire [7:0] i_wdata_n,     // write data bus
  input  wire       i_wpar_n,      // write parity
  input  wire       i_wstrobe_n,   // write strobe
  input  wire       i_amp_reset_n, // amp reset
  input  wire       i_rewind_n,    // rewind
  output wire [8:0] o_status_n,    // status pins
  output reg  [7:0] o_rdata_n,     // read data bus
  output reg        o_rpar_n,      // read parity
  output reg        o_rstrobe_n,   // read strobe
  output reg  [8:0] o_last_char,   // last written, parity on top
  output reg  [3:0] o_amp_count,   // amp resets seen
  output reg  [3:0] o_rew_count    // rewinds seen
);
  wire picked = !i_select_n[DRIVE_NO];

  assign o_status_n = picked ? ~i_status : 9'h1FF;

  initial
  begin
    o_rdata_n   = 8'h00;
    o_rpar_n    = 1'b1;
    o_rstrobe_n = 1'b1;
    o_last_char = 9'h000;
    o_amp_count = 4'h0;
    o_rew_count = 4'h0;
  end

  always @(negedge i_wstrobe_n)
    if (picked)
      o_last_char <= {~i_wpar_n, ~i_wdata_n};

  always @(negedge i_amp_reset_n)
    if (picked)
      o_amp_count <= o_amp_count + 4'h1;

  always @(negedge i_rewind_n)
    if (picked)
      o_rew_count <= o_rew_count + 4'h1;

  // one character per 480 ns call, strobe low 160 ns, bus then driven with the uninverted character
  task send_char(input [7:0] d, input p);
    o_rdata_n = ~d;
    o_rpar_n = ~p;
    #160 o_rstrobe_n = 1'b0;
    #160 o_rstrobe_n = 1'b1;
    #160 o_rdata_n = d;
    o_rpar_n = p;
  endtask
endmodule

/* tb.sv */
// Purpose: self-checking bench for the tape drive interface controller
// Assumes: drive model answers as drive 3
// Notes:   registers reached over classic wishbone
`timescale 1ns/1ps
`include "tdi_defs.vh"

module tb;
  localparam [7:0] adr_cmd = {`TDI_IDX_CMD, 2'b00};
  localparam [7:0] adr_stat = {`TDI_IDX_STAT, 2'b00};
  localparam [7:0] adr_wdata = {`TDI_IDX_WDATA, 2'b00};
  localparam [7:0] adr_rdata = {`TDI_IDX_RDATA, 2'b00};
  localparam [7:0] adr_lrc = {`TDI_IDX_LRC, 2'b00};
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         cyc = 1'b0;
  reg         stb = 1'b0;
  reg         we = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [3:0]  sel = 4'hF;
  reg  [31:0] wdat = 32'h0;
  reg  [8:0]  status = 9'h000;
  wire [31:0] rdat;
  wire        ack, we_n, fwd_n, rev_n, rew_n, edit_n, hd_n, wp_n, ws_n, amp_n, thr_n, rp_n, rs_n;
  wire [7:0]  sel_n, wd_n, rd_n;
  wire [8:0]  st_n, last;
  wire [3:0]  ampc, rewc;
  integer     bad_count = 0;
  integer     num_checks = 0;

  tdi_ctrl dut (.i_clock(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_drive_select_n(sel_n),
    .o_write_enable_out_n(we_n), .o_sync_forward_cmd_n(fwd_n), .o_sync_reverse_cmd_n(rev_n),
    .o_rewind_cmd_n(rew_n), .o_edit_mode_cmd_n(edit_n), .o_high_density_select_n(hd_n),
    .o_write_data_n(wd_n), .o_write_parity_line_n(wp_n), .o_write_char_strobe_n(ws_n),
    .o_write_amp_reset_n(amp_n), .o_read_threshold_two_n(thr_n), .i_drive_on_line_n(st_n[0]),
    .i_drive_ready_n(st_n[1]), .i_at_load_point_n(st_n[2]), .i_at_tape_end_marker_n(st_n[3]),
    .i_drive_rewinding_n(st_n[4]), .i_write_protected_n(st_n[5]), .i_seven_track_n(st_n[6]),
    .i_speed_indicator_n(st_n[7]), .i_nrz_unit_n(st_n[8]), .i_read_data_n(rd_n),
    .i_read_parity_line_n(rp_n), .i_read_char_strobe_n(rs_n));

  tdi_drive_model #(.DRIVE_NO(3)) drive (.i_select_n(sel_n), .i_status(status), .i_wdata_n(wd_n),
    .i_wpar_n(wp_n), .i_wstrobe_n(ws_n), .i_amp_reset_n(amp_n), .i_rewind_n(rew_n), .o_status_n(st_n),
    .o_rdata_n(rd_n), .o_rpar_n(rp_n), .o_rstrobe_n(rs_n), .o_last_char(last), .o_amp_count(ampc),
    .o_rew_count(rewc));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task check(input [31:0] seen, input [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    integer n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    @(posedge clk);
    while (ack !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n = n + 1;
    end
    if (n == 100)
      bad_count = bad_count + 1;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task rdck(input [7:0] a, input [31:0] m, input [31:0] e);
    reg [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask

  // poll a status bit until it reads v
  task wait_stat(input integer b, input v);
    reg [31:0] q;
    integer n;
    n = 0;
    wb(1'b0, adr_stat, 32'h0, q);
    while (q[b] !== v && n < 200)
    begin
      wb(1'b0, adr_stat, 32'h0, q);
      n = n + 1;
    end
    if (n == 200)
      bad_count = bad_count + 1;
  endtask

  task give_verdict;
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #2000000;
    bad_count = bad_count + 1;
    give_verdict;
  end

  initial
  begin
    integer k;
    reg [7:0] c;
    reg [8:0] lrc;
    reg [31:0] v;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({sel_n, we_n, fwd_n, rev_n, rew_n, edit_n, hd_n, ws_n, amp_n, thr_n}, 32'h1FFFF);
    rdck(adr_cmd, 32'hFFFFFFFF, 32'h0);
    for (k = 0; k < 8; k = k + 1)
    begin
      wr(adr_cmd, 32'h8 | k);
      repeat (2) @(posedge clk);
      check({24'h0, sel_n}, {24'h0, ~(8'h01 << k)});
    end
    wr(8'h40, 32'hB);
    rdck(adr_cmd, 32'h1FF, 32'hF);
    rdck(8'hFC, 32'hFFFFFFFF, 32'h0);
    wr(adr_cmd, 32'hB);
    for (k = 0; k < 2; k = k + 1)
    begin
      status <= k ? 9'h15A : 9'h0A5;
      repeat (4) @(posedge clk);
      rdck(adr_stat, 32'h1FF, k ? 32'h15A : 32'h0A5);
    end
    wr(adr_cmd, 32'h3);
    repeat (2) @(posedge clk);
    rdck(adr_stat, 32'h1FF, 32'h0);
    status <= 9'h003;
    for (k = 0; k < 5; k = k + 1)
    begin
      v = (k == 4) ? 32'h60 : 32'h20 << k;
      wr(adr_cmd, 32'hB | v);
      repeat (2) @(posedge clk);
      c = {3'h0, ~{v[5] & !v[6], v[6] & !v[5], v[7], v[8], 1'b0}};
      check({fwd_n, rev_n, edit_n, hd_n, we_n}, c);
    end
    wr(adr_cmd, 32'h20B);
    wait_stat(9, 1'b0);
    check(rewc, 4'h1);
    status <= 9'h023;
    repeat (4) @(posedge clk);
    wr(adr_cmd, 32'h1B);
    rdck(adr_cmd, 32'h1FF, 32'hB);
    rdck(adr_stat, 32'h400, 32'h400);
    wr(adr_stat, 32'h400);
    rdck(adr_stat, 32'h400, 32'h0);
    status <= 9'h003;
    repeat (4) @(posedge clk);
    wr(adr_cmd, 32'h1B);
    repeat (2) @(posedge clk);
    check(we_n, 1'b0);
    lrc = 9'h000;
    for (k = 0; k < 4; k = k + 1)
    begin
      v = 32'h3CFF00A5 >> (8 * k);
      c = v[7:0];
      wr(adr_wdata, {24'h0, c});
      wait_stat(9, 1'b0);
      check({23'h0, last}, {23'h0, ~^c, c});
      lrc = lrc ^ {~^c, c};
    end
    wr(adr_cmd, 32'h41B);
    wait_stat(9, 1'b0);
    check(ampc, 4'h1);
    rdck(adr_lrc, 32'h1FF, {23'h0, lrc});
    wr(adr_cmd, 32'hB);
    drive.send_char(8'h3C, 1'b1);
    wait_stat(11, 1'b1);
    rdck(adr_rdata, 32'h7FF, 32'h53C);
    rdck(adr_rdata, 32'h400, 32'h0);
    drive.send_char(8'h81, 1'b0);
    wait_stat(11, 1'b1);
    rdck(adr_rdata, 32'h7FF, 32'h681);
    drive.send_char(8'h11, 1'b1);
    drive.send_char(8'h22, 1'b1);
    repeat (8) @(posedge clk);
    rdck(adr_stat, 32'h1000, 32'h1000);
    give_verdict;
  end
endmodule

bind tdi_ctrl tdi_ctrl_sva chk (.i_clock, .i_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
  .i_wb_dat, .o_wb_ack, .o_drive_select_n, .o_write_enable_out_n, .o_sync_forward_cmd_n,
  .o_sync_reverse_cmd_n, .o_rewind_cmd_n, .o_write_data_n, .o_write_parity_line_n,
  .o_write_char_strobe_n, .o_write_amp_reset_n, .o_read_threshold_two_n, .i_write_protected_n);
